// ==== verilog/uivu_pkg.sv ====
// package of register map, vector codes and carrier types for the interrupt vector unit
package uivu_pkg;

	localparam logic [15:0] ADDR_SOURCE_CODE  = 16'hffb2;
	localparam logic [15:0] ADDR_IN_PENDING   = 16'hffb3;
	localparam logic [15:0] ADDR_OUT_PENDING  = 16'hffb4;

	localparam logic [7:0]  RESET_PENDING     = 8'h00;
	localparam logic [5:0]  CODE_OUT_EP_BASE  = 6'h00;
	localparam logic [5:0]  CODE_IN_EP_BASE   = 6'h08;
	localparam logic [5:0]  CODE_OUT_EP0      = 6'h00;
	localparam logic [5:0]  CODE_IN_EP0       = 6'h08;
	localparam logic [5:0]  CODE_NONE         = 6'h24;
	localparam int          NUM_SOURCES       = 34;   // codes 00h..21h
	localparam logic [33:0] VALID_CODE_MASK   = 34'h3_b3fd_ffff; // excludes 11h,1ah,1bh,1eh
	localparam logic [5:0]  CODE_EXT          = 6'h1f;

	// one-cycle event strobes from the sources outside this block
	typedef struct packed {
		logic       setup_overwrite; // 10h
		logic       setup_stage;     // 12h
		logic       pseudo_sof;      // 13h
		logic       sof;             // 14h
		logic       resume;          // 15h
		logic       suspend;         // 16h
		logic       bus_reset;       // 17h
		logic       cport_rx_full;   // 18h
		logic       cport_tx_empty;  // 19h
		logic       i2c_rx_full;     // 1ch
		logic       i2c_tx_empty;    // 1dh
		logic       dma0_done;       // 20h
		logic       dma1_done;       // 21h
	} uivu_events_t;

	// microcontroller register access
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} uivu_cpu_req_t;

endpackage : uivu_pkg

// ==== verilog/uivu_prio_enc.sv ====
// priority encoder picking the vector code of the highest pending source
`timescale 1ns/1ps
module uivu_prio_enc (
	input  wire logic [33:0] pending,
	output logic      [5:0]  code
);

	// scan upward so the highest index wins, external input tops the list, endpoint zero overrides all
	always_comb begin
		code = uivu_pkg::CODE_NONE;
		for (int i = 0; i < uivu_pkg::NUM_SOURCES; i++) begin
			if (pending[i] && uivu_pkg::VALID_CODE_MASK[i]) begin
				code = 6'(i);
			end
		end
		if (pending[uivu_pkg::CODE_EXT]) begin
			code = uivu_pkg::CODE_EXT;
		end
		if (pending[uivu_pkg::CODE_IN_EP0]) begin
			code = uivu_pkg::CODE_IN_EP0;
		end
		if (pending[uivu_pkg::CODE_OUT_EP0]) begin
			code = uivu_pkg::CODE_OUT_EP0;
		end
	end

endmodule // uivu_prio_enc

// ==== verilog/uivu_top.sv ====
// interrupt collection and vectoring unit with its three registers
`timescale 1ns/1ps
module uivu_top (
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	input  wire uivu_pkg::uivu_cpu_req_t  cpu_req,
	output logic      [7:0]               cpu_rdata,
	input  wire logic [7:0]               out_ep_done,
	input  wire logic [7:0]               in_ep_done,
	input  wire logic [7:0]               out_ep_iso,
	input  wire logic [7:0]               in_ep_iso,
	input  wire uivu_pkg::uivu_events_t   events,
	input  wire logic                     ext_irq_in,
	input  wire logic                     ext_irq_enable,
	output logic                          cpu_irq_line
);

	logic [33:0] pend_q;
	logic [33:0] pend_d;
	logic [33:0] set_vec;
	logic [33:0] ack_vec;
	logic [5:0]  code_w;
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;
	wire         vec_wr;
	wire         ext_active;

	// set requests per code; endpoints gated by isochronous flag
	assign set_vec[7:0]   = out_ep_done & ~out_ep_iso;
	assign set_vec[15:8]  = in_ep_done & ~in_ep_iso;
	assign set_vec[16]    = events.setup_overwrite;
	assign set_vec[17]    = 1'b0;
	assign set_vec[18]    = events.setup_stage;
	assign set_vec[19]    = events.pseudo_sof;
	assign set_vec[20]    = events.sof;
	assign set_vec[21]    = events.resume;
	assign set_vec[22]    = events.suspend;
	assign set_vec[23]    = events.bus_reset;
	assign set_vec[24]    = events.cport_rx_full;
	assign set_vec[25]    = events.cport_tx_empty;
	assign set_vec[27:26] = 2'b00;
	assign set_vec[28]    = events.i2c_rx_full;
	assign set_vec[29]    = events.i2c_tx_empty;
	assign set_vec[30]    = 1'b0;
	assign set_vec[31]    = ext_active;
	assign set_vec[32]    = events.dma0_done;
	assign set_vec[33]    = events.dma1_done;

	// external input is a level, counted only when enabled
	assign ext_active = ext_irq_in & ext_irq_enable;

	uivu_prio_enc u_prio (
		.pending (pend_q),
		.code    (code_w)
	);

	// write to the vector register acknowledges the code shown
	assign vec_wr = cpu_req.wr && (cpu_req.addr == uivu_pkg::ADDR_SOURCE_CODE);
	assign ack_vec = (vec_wr && code_w != uivu_pkg::CODE_NONE) ? (34'h1 << code_w) : 34'h0;

	// set wins over clear in the same cycle
	assign pend_d = (pend_q & ~ack_vec) | set_vec;

	// read mux; pending registers are read-only, writes to them dropped
	assign rdata_d = (cpu_req.addr == uivu_pkg::ADDR_SOURCE_CODE) ? {2'b00, code_w} :
	                 (cpu_req.addr == uivu_pkg::ADDR_IN_PENDING)  ? pend_q[15:8] :
	                 (cpu_req.addr == uivu_pkg::ADDR_OUT_PENDING) ? pend_q[7:0] :
	                 8'h00;

	// pending state and registered read data
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pend_q  <= {4'h0, 6'h00, uivu_pkg::RESET_PENDING, uivu_pkg::RESET_PENDING, uivu_pkg::RESET_PENDING};
			rdata_q <= 8'h00;
		end else begin
			pend_q  <= pend_d;
			rdata_q <= cpu_req.rd ? rdata_d : rdata_q;
		end
	end

	assign cpu_rdata = rdata_q;

	// single request line: OR of every pending source
	assign cpu_irq_line = |pend_q;

	a_irq_vs_code: assert property (@(posedge clk_sys) disable iff (reset)
		cpu_irq_line == (code_w != uivu_pkg::CODE_NONE)) else $error("irq and vector disagree");
	a_iso_no_set: assert property (@(posedge clk_sys) disable iff (reset)
		(out_ep_done[4] && out_ep_iso[4] && !pend_q[4]) |=> !pend_q[4]) else $error("iso endpoint set");
	a_out_set: assert property (@(posedge clk_sys) disable iff (reset)
		(out_ep_done[2] && !out_ep_iso[2]) |=> pend_q[2]) else $error("out pending not set");
	a_in_set: assert property (@(posedge clk_sys) disable iff (reset)
		(in_ep_done[5] && !in_ep_iso[5]) |=> pend_q[13]) else $error("in pending not set");
	a_ack_clears: assert property (@(posedge clk_sys) disable iff (reset)
		(vec_wr && code_w == 6'h14 && !events.sof) |=> !pend_q[20]) else $error("ack did not clear");
	a_ep0_first: assert property (@(posedge clk_sys) disable iff (reset)
		pend_q[0] |-> code_w == 6'h00) else $error("ep0 lost priority");
	a_ext_gate: assert property (@(posedge clk_sys) disable iff (reset)
		(!ext_irq_enable && !pend_q[31]) |=> !pend_q[31]) else $error("ext set while disabled");
	a_no_reserved: assert property (@(posedge clk_sys) disable iff (reset)
		code_w <= 6'h24 && code_w != 6'h11 && code_w != 6'h1a && code_w != 6'h1b && code_w != 6'h1e
		&& code_w != 6'h22 && code_w != 6'h23) else $error("reserved code shown");
	a_dma_prio: assert property (@(posedge clk_sys) disable iff (reset)
		(pend_q[33] && !pend_q[31] && !pend_q[0] && !pend_q[8]) |-> code_w == 6'h21) else $error("dma1 not top");
	a_ext_top: assert property (@(posedge clk_sys) disable iff (reset)
		(pend_q[31] && !pend_q[0] && !pend_q[8]) |-> code_w == 6'h1f) else $error("ext lost priority");
	a_idle_code: assert property (@(posedge clk_sys) disable iff (reset)
		(pend_q == 34'h0) |-> code_w == 6'h24) else $error("idle code wrong");

endmodule // uivu_top

// ==== testbench/uivu_mcu_model.sv ====
// microcontroller model reaching the vector unit registers
`timescale 1ns/1ps
module uivu_mcu_model (
	input  wire logic               clk_sys,
	output uivu_pkg::uivu_cpu_req_t cpu_req,
	input  wire logic [7:0]         cpu_rdata
);
	// one-cycle strobe from a falling edge; released address is scrambled, any write data acks
	task automatic access(input logic w, input logic [15:0] a, output logic [7:0] d);
		cpu_req = '{rd: !w, wr: w, addr: a, wdata: 8'h5a};
		@(negedge clk_sys);
		cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'ha5};
		@(negedge clk_sys);
		d = cpu_rdata;
	endtask
	initial cpu_req = '0;
endmodule // uivu_mcu_model

// ==== testbench/tb.sv ====
// self-checking bench for the interrupt vector unit
`timescale 1ns/1ps
module tb;
	logic                    clk_sys = 0, reset = 1, ext_in = 0, ext_en = 0, cpu_irq_line;
	logic [7:0]              cpu_rdata, rd, oe_done = 0, ie_done = 0, oe_iso = 0, ie_iso = 0;
	logic [5:0]              c;
	uivu_pkg::uivu_cpu_req_t cpu_req;
	uivu_pkg::uivu_events_t  events = '0;
	int                      fails = 0, n_checks = 0;
	localparam logic [5:0] EV_CODE [13] = '{6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
		6'h18, 6'h19, 6'h1c, 6'h1d, 6'h20, 6'h21};
	localparam logic [7:0] PRIO [5] = '{8'h00, 8'h08, 8'h21, 8'h03, 8'h24};
	always #10 clk_sys = ~clk_sys;
	uivu_top i_uivu_top (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
		.out_ep_done(oe_done), .in_ep_done(ie_done), .out_ep_iso(oe_iso), .in_ep_iso(ie_iso),
		.events(events), .ext_irq_in(ext_in), .ext_irq_enable(ext_en), .cpu_irq_line(cpu_irq_line));
	uivu_mcu_model i_uivu_mcu_model (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata));
	// compare and count
	task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		i_uivu_mcu_model.access(1'b0, a, rd);
		cmp("rdata", exp, rd);
	endtask
	task automatic ack();
		i_uivu_mcu_model.access(1'b1, 16'hffb2, rd);
	endtask
	// one-cycle pulse of source k: out eps, in eps, then events
	task automatic fire(input int k);
		if (k < 8) oe_done[k] = 1'b1;
		else if (k < 16) ie_done[k-8] = 1'b1;
		else events = 13'h1 << (28 - k);
		@(negedge clk_sys);
		{oe_done, ie_done, events} = '0;
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#100us;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		reset = 0;
		cmp("irq", 8'h00, {7'h0, cpu_irq_line});
		rdchk(16'hffb2, 8'h24);
		rdchk(16'hffb3, 8'h00);
		rdchk(16'hffb4, 8'h00);
		// each endpoint and event source alone: code, pending bit for endpoints only, acknowledge
		for (int k = 0; k < 29; k++) begin
			c = (k < 16) ? 6'(k) : EV_CODE[k-16];
			fire(k);
			cmp("irq", 8'h01, {7'h0, cpu_irq_line});
			rdchk(16'hffb2, {2'b00, c});
			if (k < 16) rdchk(k < 8 ? 16'hffb4 : 16'hffb3, 8'h1 << (k % 8));
			ack();
			rdchk(16'hffb2, 8'h24);
		end
		// several pending: out ep0 then in ep0 first, then highest code first
		oe_done = 8'h09;
		ie_done = 8'h01;
		events = 13'h1;
		@(negedge clk_sys);
		{oe_done, ie_done, events} = '0;
		i_uivu_mcu_model.access(1'b1, 16'hffb4, rd);
		rdchk(16'hffb4, 8'h09);
		foreach (PRIO[i]) begin
			rdchk(16'hffb2, PRIO[i]);
			ack();
		end
		rdchk(16'hffb4, 8'h00);
		// isochronous completions ignored
		{oe_iso, ie_iso} = '1;
		fire(4);
		fire(12);
		cmp("irq", 8'h00, {7'h0, cpu_irq_line});
		rdchk(16'hffb3, 8'h00);
		{oe_iso, ie_iso} = '0;
		// external input gated by enable
		ext_in = 1;
		repeat (2) @(negedge clk_sys);
		cmp("irq", 8'h00, {7'h0, cpu_irq_line});
		ext_en = 1;
		fire(27);
		rdchk(16'hffb2, 8'h1f);
		ext_in = 0;
		ack();
		rdchk(16'hffb2, 8'h20);
		ack();
		rdchk(16'hffb2, 8'h24);
		cmp("irq", 8'h00, {7'h0, cpu_irq_line});
		rdchk(16'h0010, 8'h00);
		give_verdict();
	end
endmodule // tb
